// >>> verilog/tcp_top.sv
// Timer channel pin control: counter, eight channels and a Wishbone
// slave holding the configuration.
// Assumes classic Wishbone on mclk; pins arrive asynchronously.
//
// Notes on behaviour
// (R1) Unit has one to eight channels, each with one two-way pin.
// (R2) Pin with no timer function enabled stays under port control.
// (R3) After reset no timer function is enabled on any pin.
// (R4) Clock source is off, bus clock, fixed clock or external pin.
// (R5) Source code 00 off, 01 bus, 10 fixed, 11 external.
// (R6) External clock is synchronised; it runs at most quarter bus rate.
// (R7) Software must not use a channel pin also used as clock input.
// (R8) With external clock, edge/level 00 channel still times, no pin.
// (R9) No pin drive when edge/level is 00 or clock source is 00.
// (R10) Center select with nonzero edge/level gives center PWM on pins.
// (R11) Mode 00 with nonzero edge/level captures count on chosen edges.
// (R12) Capture input synchronised; pulses of four clocks are seen.
// (R13) Mode 01 drives pin and acts when value equals count.
// (R14) Compare action: 01 toggles, 10 clears, 11 sets the pin.
// (R15) Toggle mode keeps previous pin level until the next match.
// (R16) Edge PWM 10: high at count zero, low at match.
// (R17) Edge PWM low bit set: low at count zero, high at match.
// (R18) Edge PWM period is modulo plus one; count only goes up.
// (R19) Center PWM 10: clear on up match, set on down match.
// (R20) Center PWM low bit set: set on up match, clear on down match.
// (R21) Center mode counts zero up to modulo and back down.
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_top (
  input  wire logic        mclk,              // Bus clock, 10 MHz.
  input  wire logic        rstn,              // Async reset, active low.
  input  wire logic        wb_cyc_i,          // Wishbone cycle.
  input  wire logic        wb_stb_i,          // Wishbone strobe.
  input  wire logic        wb_we_i,           // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,          // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,          // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,          // Wishbone write data.
  output logic      [31:0] wb_dat_o,          // Wishbone read data.
  output logic             wb_ack_o,          // Wishbone acknowledge.
  input  wire logic        external_count_clock_pin, // External clock.
  input  wire logic        fixed_clock_in,    // Fixed system clock.
  input  wire logic [7:0]  channel_pin_i,     // Channel pin levels.
  output logic      [7:0]  channel_pin_o,     // Channel pin drive.
  output logic      [7:0]  channel_pin_oe     // Channel pin enables.
);

  tcp_pkg::tcp_core_t st_q;
  tcp_pkg::tcp_core_t st_d;
  logic [9:0]         sync_q;
  logic [7:0]         pin_sync;
  logic               ext_sync;
  logic               fix_sync;
  logic [7:0][15:0]   ch_val;
  logic [7:0]         ch_evt;
  logic [7:0]         ch_wr;
  logic [15:0]        wr_word;
  logic               req;
  logic               tick;
  logic [15:0]        top;
  logic [2:0]         region;
  logic [2:0]         idx;

  // All pins cross into mclk through two flip-flops.
  tcp_sync #(
    .W (10)
  ) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    ({fixed_clock_in, external_count_clock_pin, channel_pin_i}),
    .q    (sync_q)
  );

  assign pin_sync = sync_q[7:0];   // R12
  assign ext_sync = sync_q[8];     // R6
  assign fix_sync = sync_q[9];

  // Bus decode and the low half of write data with byte lanes applied.
  always_comb begin
    req     = wb_cyc_i && wb_stb_i && !st_q.ack;
    region  = wb_adr_i[7:5];
    idx     = wb_adr_i[4:2];
    wr_word = st_q.modv;
    if (region == `TCP_CH_VAL_BASE) begin
      wr_word = ch_val[idx];
    end
    if (wb_sel_i[0]) begin
      wr_word[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wr_word[15:8] = wb_dat_i[15:8];
    end
    ch_wr = 8'h00;
    if (req && wb_we_i && (region == `TCP_CH_VAL_BASE)) begin
      ch_wr[idx] = 1'b1;
    end
  end

  // Counter clock source selection.
  always_comb begin
    case (st_q.css)                                            // R4 R5
      `TCP_CSS_BUS:   tick = 1'b1;
      `TCP_CSS_FIXED: tick = fix_sync && !st_q.fix_prev;
      `TCP_CSS_EXT:   tick = ext_sync && !st_q.ext_prev;       // R6
      default:        tick = 1'b0;
    endcase
    top = (st_q.modv == 16'h0000) ? `TCP_FREE_TOP : st_q.modv;
  end

  // Next state: counter, flags and the register file.
  always_comb begin
    st_d          = st_q;
    st_d.ext_prev = ext_sync;
    st_d.fix_prev = fix_sync;
    st_d.step     = tick;
    st_d.ack      = req;
    // Counting.
    if (tick) begin
      if (!st_q.center_aligned_select) begin
        st_d.dir = tcp_pkg::TCP_UP;                            // R18
        if (st_q.cnt == top) begin
          st_d.cnt = 16'h0000;                                 // R18
        end else begin
          st_d.cnt = st_q.cnt + 16'h0001;
        end
      end else if (st_q.dir == tcp_pkg::TCP_UP) begin
        if (st_q.cnt >= top) begin
          st_d.dir = tcp_pkg::TCP_DOWN;                        // R21
          st_d.cnt = st_q.cnt - 16'h0001;
        end else begin
          st_d.cnt = st_q.cnt + 16'h0001;
        end
      end else begin
        if (st_q.cnt == 16'h0000) begin
          st_d.dir = tcp_pkg::TCP_UP;                          // R21
          st_d.cnt = 16'h0001;
        end else begin
          st_d.cnt = st_q.cnt - 16'h0001;
        end
      end
    end
    // Read data for the access being answered.
    st_d.rdat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `TCP_ADR_CTRL:  st_d.rdat = {29'h0, st_q.center_aligned_select, st_q.css};
        `TCP_ADR_MOD:   st_d.rdat = {16'h0, st_q.modv};
        `TCP_ADR_COUNT: st_d.rdat = {15'h0, st_q.dir, st_q.cnt};
        `TCP_ADR_FLAGS: st_d.rdat = {24'h0, st_q.flags};
        `TCP_ADR_PINS:  st_d.rdat = {16'h0, channel_pin_oe, pin_sync};
        default: begin
          if (region == `TCP_CH_CFG_BASE) begin
            st_d.rdat = {28'h0, st_q.cfg[idx]};
          end else if (region == `TCP_CH_VAL_BASE) begin
            st_d.rdat = {16'h0, ch_val[idx]};
          end
        end
      endcase
    end
    // Register writes; unmapped addresses are acknowledged and ignored.
    if (req && wb_we_i) begin
      case (wb_adr_i)
        `TCP_ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            st_d.css   = wb_dat_i[`TCP_CTRL_CSS_LSB +: 2];     // R5
            st_d.center_aligned_select = wb_dat_i[`TCP_CTRL_CENTER_ALIGNED_SELECT];            // R10
          end
        end
        `TCP_ADR_MOD: st_d.modv = wr_word;
        `TCP_ADR_COUNT: begin
          // Any write restarts the count, whatever the data.
          st_d.cnt = 16'h0000;
          st_d.dir = tcp_pkg::TCP_UP;
        end
        `TCP_ADR_FLAGS: begin
          if (wb_sel_i[0]) begin
            st_d.flags = st_q.flags & ~wb_dat_i[7:0];
          end
        end
        default: begin
          if ((region == `TCP_CH_CFG_BASE) && wb_sel_i[0]) begin
            st_d.cfg[idx] = wb_dat_i[3:0];
          end
        end
      endcase
    end
    // Channel events set flags; a set wins over a clear.
    st_d.flags = st_d.flags | ch_evt;
  end

  // Core state register; reset leaves every channel disabled.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= '0;                                        // R3
      {st_q.center_aligned_select, st_q.css} <= `TCP_RST_CTRL;
      st_q.cfg   <= {`TCP_NCH{`TCP_RST_CFG}};                  // R3
      st_q.modv  <= `TCP_RST_MOD;
    end else begin
      st_q <= st_d;
    end
  end

  // One channel per pin.
  for (genvar n = 0; n < `TCP_NCH; n++) begin : g_ch             // R1
    tcp_chan u_chan (
      .mclk     (mclk),
      .rstn     (rstn),
      .css      (st_q.css),
      .center_aligned_select    (st_q.center_aligned_select),
      .mode     (st_q.cfg[n][`TCP_CFG_MODE_LSB +: 2]),
      .els      (st_q.cfg[n][`TCP_CFG_ELS_LSB +: 2]),
      .cnt      (st_q.cnt),
      .dir      (st_q.dir),
      .step     (st_q.step),
      .pin_sync (pin_sync[n]),
      .wr_en    (ch_wr[n]),
      .wr_data  (wr_word),
      .val      (ch_val[n]),
      .pin_out  (channel_pin_o[n]),
      .pin_oe   (channel_pin_oe[n]),
      .evt      (ch_evt[n])
    );
  end

  assign wb_dat_o = st_q.rdat;
  assign wb_ack_o = st_q.ack;

endmodule

// >>> verilog/tcp_params.svh
// Constants for the timer channel pin control block.
// Assumes inclusion by bare name from each design file.
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// Number of channels in this timer unit.
`define TCP_NCH           8
// Register word offsets, byte addresses on the bus.
`define TCP_ADR_CTRL      8'h00
`define TCP_ADR_MOD       8'h04
`define TCP_ADR_COUNT     8'h08
`define TCP_ADR_FLAGS     8'h0c
`define TCP_ADR_PINS      8'h10
`define TCP_CH_CFG_BASE   3'h1
`define TCP_CH_VAL_BASE   3'h2
// Field positions in the control register.
`define TCP_CTRL_CSS_LSB  0
`define TCP_CTRL_CENTER_ALIGNED_SELECT    2
// Field positions in a channel configuration register.
`define TCP_CFG_ELS_LSB   0
`define TCP_CFG_MODE_LSB  2
// Clock source encodings.
`define TCP_CSS_OFF       2'h0
`define TCP_CSS_BUS       2'h1
`define TCP_CSS_FIXED     2'h2
`define TCP_CSS_EXT       2'h3
// Reset values.
`define TCP_RST_CTRL      3'h0
`define TCP_RST_MOD       16'h0000
`define TCP_RST_CFG       4'h0
`define TCP_RST_VAL       16'h0000
// Count value treated as top when the modulo is zero.
`define TCP_FREE_TOP      16'hffff

`endif

// >>> verilog/tcp_pkg.sv
// Types shared by the timer channel pin control block.
// Assumes the parameter header is compiled alongside.
package tcp_pkg;

  // Counting direction, one bit so trivially Gray coded.
  typedef enum logic {
    TCP_UP   = 1'b0,
    TCP_DOWN = 1'b1
  } tcp_dir_t;

  // Whole state of the core.
  typedef struct packed {
    logic [1:0]      css;
    logic            center_aligned_select;
    logic [15:0]     modv;
    logic [15:0]     cnt;
    tcp_dir_t        dir;
    logic            step;
    logic [7:0]      flags;
    logic [7:0][3:0] cfg;
    logic            ack;
    logic [31:0]     rdat;
    logic            ext_prev;
    logic            fix_prev;
  } tcp_core_t;

  // Whole state of one channel.
  typedef struct packed {
    logic [15:0] val;
    logic        out;
    logic        prev;
    logic        evt;
  } tcp_chan_t;

  // Whole state of a two-stage synchroniser.
  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
  } tcp_sync_t;

endpackage

// >>> verilog/tcp_sync.sv
// Two flip-flop synchroniser for pins arriving from outside mclk.
// Assumes W is at most 10, the width held in the package type.
`timescale 1ns/1ps
module tcp_sync #(
  parameter int W = 10
) (
  input  wire logic         mclk,  // Bus clock.
  input  wire logic         rstn,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,     // Asynchronous inputs.
  output logic      [W-1:0] q      // Synchronised inputs.
);

  tcp_pkg::tcp_sync_t st_q;
  tcp_pkg::tcp_sync_t st_d;

  // The first stage feeds only the second stage.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = 10'(d);
    st_d.s2 = st_q.s1;
  end

  // State register.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2[W-1:0];

endmodule

// >>> verilog/tcp_chan.sv
// One timer channel: capture, compare and both PWM forms on one pin.
// Assumes pin_sync is already synchronised and count updates are
// flagged by step in the same cycle as the new count appears.
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_chan (
  input  wire logic             mclk,      // Bus clock.
  input  wire logic             rstn,      // Asynchronous reset, low.
  input  wire logic [1:0]       css,       // Clock source select.
  input  wire logic             center_aligned_select,     // Center-aligned select.
  input  wire logic [1:0]       mode,      // Channel mode select.
  input  wire logic [1:0]       els,       // Edge/level select.
  input  wire logic [15:0]      cnt,       // Timer count.
  input  wire tcp_pkg::tcp_dir_t dir,      // Count direction.
  input  wire logic             step,      // Count just changed.
  input  wire logic             pin_sync,  // Synchronised pin level.
  input  wire logic             wr_en,     // Software value write.
  input  wire logic [15:0]      wr_data,   // Value to write.
  output logic [15:0]           val,       // Channel value.
  output logic                  pin_out,   // Pin output level.
  output logic                  pin_oe,    // Pin output enable.
  output logic                  evt        // Capture or match pulse.
);

  tcp_pkg::tcp_chan_t st_q;
  tcp_pkg::tcp_chan_t st_d;
  logic               active;
  logic               own_out;
  logic               capture;
  logic               edge_hit;
  logic               match;

  // Ownership of the pin and the compare condition.
  always_comb begin
    active   = (els != 2'h0) && (css != `TCP_CSS_OFF);  // R9 R2 R3
    own_out  = active && (center_aligned_select || (mode != 2'h0));      // R10 R13
    capture  = active && !center_aligned_select && (mode == 2'h0);       // R11
    edge_hit = (els[0] && pin_sync && !st_q.prev) ||
               (els[1] && !pin_sync && st_q.prev);       // R11 R12
    match    = step && (cnt == st_q.val) &&
               (css != `TCP_CSS_OFF);                    // R8
  end

  // Next state of the channel.
  always_comb begin
    st_d      = st_q;
    st_d.prev = pin_sync;
    st_d.evt  = 1'b0;
    if (!own_out) begin
      // Track the pin so a newly owned output starts at its level.
      st_d.out = pin_sync;                               // R15
    end
    if (center_aligned_select) begin
      if (match && active) begin
        st_d.evt = 1'b1;
        if (dir == tcp_pkg::TCP_UP) begin
          st_d.out = els[0];                             // R19 R20
        end else begin
          st_d.out = !els[0];                            // R19 R20
        end
      end
    end else if (mode[1]) begin
      if (active && step && (cnt == 16'h0000)) begin
        st_d.out = !els[0];                              // R16 R17
      end
      if (match && active) begin
        st_d.evt = 1'b1;
        st_d.out = els[0];                               // R16 R17
      end
    end else if (mode == 2'h1) begin
      if (match) begin
        st_d.evt = 1'b1;                                 // R8
        case (els)
          2'h1:    st_d.out = !st_q.out;                 // R14 R15
          2'h2:    st_d.out = 1'b0;                      // R14
          2'h3:    st_d.out = 1'b1;                      // R14
          default: st_d.out = st_d.out;
        endcase
      end
    end else if (capture && edge_hit) begin
      st_d.evt = 1'b1;
      st_d.val = cnt;                                    // R11
    end
    if (wr_en) begin
      st_d.val = wr_data;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= {`TCP_RST_VAL, 3'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign val     = st_q.val;
  assign pin_out = st_q.out;
  assign pin_oe  = own_out;
  assign evt     = st_q.evt;

endmodule

// >>> test/tcp_pin_model.sv
// Board-side model of the channel pins and of the two count clocks.
// Assumes the testbench sets board levels and starts the clocks.
`timescale 1ns/1ps
module tcp_pin_model (
  input  wire logic       mclk,    // Bus clock.
  input  wire logic       rstn,    // Reset, active low.
  input  wire logic [7:0] drv_o,   // Timer pin drive.
  input  wire logic [7:0] drv_oe,  // Timer pin enables.
  input  wire logic [7:0] lvl,     // Board levels.
  input  wire logic       run,     // Count clocks run.
  output logic      [7:0] pin,     // Resolved pin levels.
  output logic            ext_clk, // External count clock.
  output logic            fix_clk  // Fixed count clock.
);
  logic [2:0] ph_q;

  // The board yields each pin while the timer drives it.
  assign pin = (drv_oe & drv_o) | (~drv_oe & lvl);

  // Phase of a clock of eight bus periods, held low outside bursts.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= run ? ph_q + 3'h1 : 3'h0;
    end
  end

  // The count clocks have their own pin, apart from any channel pin.
  assign ext_clk = run & ph_q[2];
  assign fix_clk = ext_clk;
endmodule

// >>> test/tcp_top_assertions.sv
// Checker for the timer channel pin control block, bound to tcp_top.
// Assumes only the ports of tcp_top are visible.
`timescale 1ns/1ps
module tcp_chk (
  input  wire logic        mclk,           // Bus clock.
  input  wire logic        rstn,           // Reset, active low.
  input  wire logic        wb_cyc_i,       // Bus cycle.
  input  wire logic        wb_stb_i,       // Bus strobe.
  input  wire logic        wb_we_i,        // Bus write.
  input  wire logic [7:0]  wb_adr_i,       // Bus address.
  input  wire logic [3:0]  wb_sel_i,       // Byte selects.
  input  wire logic [31:0] wb_dat_i,       // Write data.
  input  wire logic [31:0] wb_dat_o,       // Read data.
  input  wire logic        wb_ack_o,       // Acknowledge.
  input  wire logic [7:0]  channel_pin_i,  // Pin levels.
  input  wire logic [7:0]  channel_pin_o,  // Pin drive.
  input  wire logic [7:0]  channel_pin_oe  // Pin enables.
);
  // All checks run on the bus clock and rest during reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside acknowledge");
  reset_free_a: assert property (
    $rose(rstn) |-> channel_pin_oe == 8'h00 && !wb_ack_o)
    else $error("pin owned after reset");
  oe_by_write_a: assert property (
    !$stable(channel_pin_oe) |-> wb_ack_o && wb_we_i)
    else $error("pin ownership changed without a write");
  oe_read_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h10
    |-> wb_dat_o[15:8] == channel_pin_oe)
    else $error("ownership readback differs from pins");
  unmapped_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 8'hfc |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  clk_off_a: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]
    && wb_dat_i[1:0] == 2'h0 |-> channel_pin_oe == 8'h00)
    else $error("pin owned with clock off");
  els_off_a: assert property (
    wb_ack_o && wb_we_i && wb_adr_i[7:5] == 3'h1 && wb_sel_i[0]
    && wb_dat_i[1:0] == 2'h0 |-> !channel_pin_oe[wb_adr_i[4:2]])
    else $error("pin owned with edge select zero");
  takeover_a: assert property (
    (channel_pin_oe & ~$past(channel_pin_oe)) != 8'h00
    |-> ((channel_pin_o ^ $past(channel_pin_i)) & channel_pin_oe
    & ~$past(channel_pin_oe)) == 8'h00)
    else $error("pin taken over at a new level");

  // Main scenarios reached.
  cover property (channel_pin_oe != 8'h00);
  cover property ($rose(channel_pin_o[1]));
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind tcp_top tcp_chk i_chk (.mclk, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .channel_pin_i, .channel_pin_o, .channel_pin_oe);

// >>> test/timer_channel_pin_control_tb.sv
// Self-checking testbench for the timer channel pin control block.
// Assumes the design, the checker and the pin model are compiled.
`timescale 1ns/1ps
module timer_channel_pin_control_tb;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  lvl = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dout;
  logic [31:0] rd;
  logic [7:0]  pin;
  logic [7:0]  po;
  logic [7:0]  poe;
  logic        ack;
  logic        xclk;
  logic        fclk;
  int          n_fail = 0;
  int          cmp_count = 0;

  tcp_top i_dut (.mclk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .external_count_clock_pin(xclk),
    .fixed_clock_in(fclk), .channel_pin_i(pin), .channel_pin_o(po),
    .channel_pin_oe(poe));
  tcp_pin_model i_pins (.mclk, .rstn, .drv_o(po), .drv_oe(poe), .lvl,
    .run, .pin, .ext_clk(xclk), .fix_clk(fclk));

  // Bus clock of 100 ns.
  always #50 mclk = ~mclk;

  // Compares a seen value with the expected one and counts both.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, s, e);
    end
  endtask

  // One classic bus cycle; read data is kept in rd.
  task automatic bus(input logic [7:0] a, input logic [31:0] d,
                     input logic w);
    int k;
    @(posedge mclk);
    {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, 4'h3, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    // Read data is taken at the very edge where ack is seen high.
    rd = dout;
    {cyc, stb} <= 2'b00;
    // A missing acknowledge counts as a mismatch.
    if (ack !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, ack, 1'b1);
    end
  endtask

  // Waits a bounded time for a pin drive level.
  task automatic wait_pin(input int c, input logic v);
    int k;
    k = 0;
    while (po[c] !== v && k < 60) begin
      @(negedge mclk);
      k++;
    end
  endtask

  // Counts the cycles a pin is driven high over n cycles.
  task automatic hi_cnt(input int c, input int n, output int h);
    h = 0;
    repeat (n) begin
      @(negedge mclk);
      h += po[c];
    end
  endtask

  task automatic t_reset();
    bus(8'h00, 32'h0, 1'b0);
    chk(rd, 32'h0);
    bus(8'h10, 32'h0, 1'b0);
    chk(rd[15:8], 8'h00);
    bus(8'hfc, 32'h5a5a, 1'b1);
    bus(8'hfc, 32'h0, 1'b0);
    chk(rd, 32'h0);
    $display("Reset test done.");
  endtask

  task automatic t_oc();
    bus(8'h40, 32'h5, 1'b1);
    bus(8'h04, 32'hf, 1'b1);
    bus(8'h20, 32'h7, 1'b1);
    chk(poe[0], 1'b0);
    bus(8'h00, 32'h1, 1'b1);
    wait_pin(0, 1'b1);
    chk({poe[0], po[0]}, 2'b11);
    bus(8'h20, 32'h6, 1'b1);
    wait_pin(0, 1'b0);
    chk(po[0], 1'b0);
    bus(8'h20, 32'h0, 1'b1);
    lvl[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(poe[0], 1'b0);
    bus(8'h40, 32'hc, 1'b1);
    bus(8'h08, 32'h0, 1'b1);
    bus(8'h20, 32'h5, 1'b1);
    chk(po[0], 1'b1);
    wait_pin(0, 1'b0);
    chk(po[0], 1'b0);
    bus(8'h20, 32'h0, 1'b1);
    $display("Compare test done.");
  endtask

  task automatic t_epwm();
    int h;
    bus(8'h04, 32'h8, 1'b1);
    // Restart the count so it cannot sit above the new modulo.
    bus(8'h08, 32'h0, 1'b1);
    bus(8'h44, 32'h5, 1'b1);
    bus(8'h24, 32'ha, 1'b1);
    repeat (20) @(posedge mclk);
    hi_cnt(1, 9, h);
    chk(h, 5);
    bus(8'h24, 32'h9, 1'b1);
    repeat (20) @(posedge mclk);
    hi_cnt(1, 9, h);
    chk(h, 4);
    $display("Edge PWM test done.");
  endtask

  task automatic t_cpwm();
    int h;
    bus(8'h48, 32'h5, 1'b1);
    bus(8'h00, 32'h5, 1'b1);
    bus(8'h28, 32'h2, 1'b1);
    chk(poe[2], 1'b1);
    repeat (40) @(posedge mclk);
    hi_cnt(2, 16, h);
    chk(h, 10);
    bus(8'h28, 32'h1, 1'b1);
    repeat (40) @(posedge mclk);
    hi_cnt(2, 16, h);
    chk(h, 6);
    bus(8'h00, 32'h1, 1'b1);
    chk(poe[2], 1'b0);
    $display("Center PWM test done.");
  endtask

  task automatic t_cap();
    for (int e = 1; e < 4; e++) begin
      bus(8'h2c, e, 1'b1);
      chk(poe[3], 1'b0);
      for (int v = 1; v >= 0; v--) begin
        bus(8'h0c, 32'hff, 1'b1);
        lvl[3] <= v[0];
        repeat (8) @(posedge mclk);
        bus(8'h0c, 32'h0, 1'b0);
        chk(rd[3], v ? e[0] : e[1]);
      end
    end
    $display("Capture test done.");
  endtask

  task automatic t_ext();
    logic [1:0] css [3] = '{2'h0, 2'h2, 2'h3};
    bus(8'h04, 32'h0, 1'b1);
    bus(8'h50, 32'h3, 1'b1);
    bus(8'h30, 32'h4, 1'b1);
    for (int i = 0; i < 3; i++) begin
      bus(8'h00, {30'h0, css[i]}, 1'b1);
      bus(8'h08, 32'h0, 1'b1);
      bus(8'h0c, 32'hff, 1'b1);
      run <= 1'b1;
      repeat (80) @(posedge mclk);
      run <= 1'b0;
      repeat (6) @(posedge mclk);
      bus(8'h08, 32'h0, 1'b0);
      chk(rd[15:0], css[i] != 2'h0 ? 16'h000a : 16'h0000);
      bus(8'h0c, 32'h0, 1'b0);
      chk({rd[4], poe[4]}, {css[i] != 2'h0, 1'b0});
    end
    $display("Clock source test done.");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence: reset for eight cycles, then each test in turn.
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_oc();
    t_epwm();
    t_cpwm();
    t_cap();
    t_ext();
    close_out();
  end

  // Watchdog: the tests need about 700 cycles, this allows 20000.
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
endmodule
